// >>> hw/emsc_top.sv
// Purpose: Drives the store and fetch strobes, address, data and chip select pins
//          of the external memory interface for one internal access at a time.
// Assumes: Pin inputs are synchronous to clk_i; one request at a time.
// Notes:   Pin outputs are registered from the next state, so they follow state_q.
//
// How it works
// - Store strobe is low during every write cycle, high otherwise.
// - While store strobe is low, all sixteen data pins drive write data.
// - Strobes qualify address and chip selects; those stay valid while strobe low.
// - Bus-drive bit chooses floating or driven address, strobes, selects when idle.
// - Chip select zero is program-space select, low on program accesses outside configured regions.
// - Chip select one is data-space select, low on data accesses outside configured regions.
// - Chip selects two and three assert for accesses in configured regions.
// - Store strobe pull-up disabled when the pull-up disable control bit is set.
// - Program-select pull-up disabled when port D pull-up bit 8 is clear.
// - Data-select pull-up disabled when port D pull-up bit 9 is clear.
// - Shared select pins individually configurable as general input or output.
// - Fetch strobe low on reads, data pins input, data captured at its rise.
`default_nettype none
module emsc_top
	import emsc_pkg::*;
#(
	parameter int unsigned STROBE_CYCLES = emsc_pkg::STROBE_CYC
) (
	input  wire logic                                              clk_i,
	input  wire logic                                              rst_i,
	input  wire logic                                              req_valid_i,
	input  wire emsc_pkg::emsc_req_t                               req_i,
	output logic                                                   req_ready_o,
	output logic                                                   done_o,
	output logic [emsc_pkg::DATA_W-1:0]                            rdata_o,
	input  wire logic                                              bus_drive_hold_i,
	input  wire emsc_pkg::emsc_region_t [emsc_pkg::NUM_REGION-1:0] region_i,
	input  wire logic [emsc_pkg::NUM_REGION-1:0]                   region_en_i,
	input  wire logic [emsc_pkg::NUM_CS-1:0]                       cs_gpio_mode_i,
	input  wire logic [emsc_pkg::NUM_CS-1:0]                       cs_gpio_out_i,
	input  wire logic [emsc_pkg::NUM_CS-1:0]                       cs_gpio_dir_i,
	input  wire logic [emsc_pkg::NUM_CS-1:0]                       cs_pin_i,
	output logic [emsc_pkg::NUM_CS-1:0]                            cs_gpio_in_o,
	input  wire logic                                              pullup_disable_ctrl_i,
	input  wire logic [15:0]                                       port_d_pullup_i,
	output logic [emsc_pkg::ADDR_W-1:0]                            address_pins_o,
	output logic                                                   address_oe_o,
	output logic                                                   store_strobe_n_o,
	output logic                                                   fetch_strobe_n_o,
	output logic                                                   strobe_oe_o,
	output logic [emsc_pkg::DATA_W-1:0]                            data_pins_o,
	output logic                                                   data_oe_o,
	input  wire logic [emsc_pkg::DATA_W-1:0]                       data_pins_i,
	output logic [emsc_pkg::NUM_CS-1:0]                            cs_n_o,
	output logic [emsc_pkg::NUM_CS-1:0]                            cs_oe_o,
	output logic                                                   strobe_pu_o,
	output logic [emsc_pkg::NUM_CS-1:0]                            cs_pu_o
);
	localparam int unsigned CNT_W = $clog2(STROBE_CYCLES + 1);

	if (STROBE_CYCLES < 1 || STROBE_CYCLES > 255) begin : g_bad_param
		$error("STROBE_CYCLES must lie between 1 and 255");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Access sequencer.

	emsc_state_t          state_q;
	emsc_state_t          state_d;
	emsc_req_t            req_q;
	logic [CNT_W-1:0]     cnt_q;
	logic [NUM_REGION-1:0] hit_w;
	logic [NUM_REGION-1:0] hit_q;
	logic                 take_w;
	emsc_req_t            req_w;
	logic [NUM_REGION-1:0] hit_sel_w;
	logic                 strobe_end_w;
	logic                 busy_d;
	logic                 strobe_d;
	logic                 drive_data_d;
	logic [NUM_CS-1:0]    sel_w;
	logic [NUM_CS-1:0]    cs_n_d;
	logic [NUM_CS-1:0]    cs_oe_d;

	assign take_w       = req_valid_i && req_ready_o;
	// A request taken on this edge is used directly, so that the setup cycle already shows
	// its own address and select instead of those of the access before it.
	assign req_w        = take_w ? req_i : req_q;
	assign hit_sel_w    = take_w ? hit_w : hit_q;
	assign strobe_end_w = (state_q == ST_STROBE) && (cnt_q == CNT_W'(STROBE_CYCLES - 1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:   if (take_w) state_d = ST_SETUP;
			ST_SETUP:  state_d = ST_STROBE;
			ST_STROBE: if (strobe_end_w) state_d = ST_HOLD;
			// Hold keeps address, select and write data one cycle past the strobe rise.
			ST_HOLD:   state_d = ST_IDLE;
			default:   state_d = ST_IDLE;
		endcase
	end

	emsc_region_dec u_region_dec (
		.addr_i      (req_i.addr),
		.region_i    (region_i),
		.region_en_i (region_en_i),
		.hit_o       (hit_w)
	);

	// Region selects win over the space selects so only one line ever goes low.
	assign sel_w[CS_REG0] = hit_sel_w[0];
	assign sel_w[CS_REG1] = hit_sel_w[1] && !hit_sel_w[0];
	assign sel_w[CS_PROG] = !(|hit_sel_w) && !req_w.data_space;
	assign sel_w[CS_DATA] = !(|hit_sel_w) && req_w.data_space;

	assign busy_d       = (state_d != ST_IDLE);
	assign strobe_d     = (state_d == ST_STROBE);
	assign drive_data_d = req_q.write && (state_d == ST_STROBE || state_d == ST_HOLD);

	for (genvar g = 0; g < NUM_CS; g++) begin : g_cs
		// A pin in general-purpose mode follows its own output and direction.
		assign cs_n_d[g]  = cs_gpio_mode_i[g] ? cs_gpio_out_i[g]
			: !(busy_d && sel_w[g]);
		assign cs_oe_d[g] = cs_gpio_mode_i[g] ? cs_gpio_dir_i[g]
			: (bus_drive_hold_i || busy_d);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			req_q   <= '0;
			hit_q   <= '0;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			if (take_w) begin
				req_q <= req_i;
				hit_q <= hit_w;
			end
			cnt_q <= (state_q == ST_STROBE) ? cnt_q + CNT_W'(1) : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin and answer registers.

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			req_ready_o      <= 1'b0;
			done_o           <= 1'b0;
			rdata_o          <= '0;
			address_pins_o   <= '0;
			address_oe_o     <= 1'b0;
			store_strobe_n_o <= STROBE_RST;
			fetch_strobe_n_o <= STROBE_RST;
			strobe_oe_o      <= 1'b0;
			data_pins_o      <= '0;
			data_oe_o        <= 1'b0;
			cs_n_o           <= CS_N_RST;
			cs_oe_o          <= '0;
		end else begin
			req_ready_o      <= (state_d == ST_IDLE);
			done_o           <= (state_q == ST_HOLD);
			address_pins_o   <= busy_d ? req_w.addr : address_pins_o;
			address_oe_o     <= bus_drive_hold_i || busy_d;
			strobe_oe_o      <= bus_drive_hold_i || busy_d;
			store_strobe_n_o <= !(strobe_d && req_q.write);
			fetch_strobe_n_o <= !(strobe_d && !req_q.write);
			data_pins_o      <= drive_data_d ? req_q.wdata : data_pins_o;
			data_oe_o        <= drive_data_d;
			cs_n_o           <= cs_n_d;
			cs_oe_o          <= cs_oe_d;
			// Read data is taken on the edge that raises the fetch strobe.
			if (strobe_end_w && !req_q.write) begin
				rdata_o <= data_pins_i;
			end
		end
	end

	emsc_pin_cfg u_pin_cfg (
		.clk_i                 (clk_i),
		.rst_i                 (rst_i),
		.pullup_disable_ctrl_i (pullup_disable_ctrl_i),
		.port_d_pullup_i       (port_d_pullup_i),
		.cs_pin_i              (cs_pin_i),
		.strobe_pu_o           (strobe_pu_o),
		.cs_pu_o               (cs_pu_o),
		.cs_gpio_in_o          (cs_gpio_in_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_write_low;
		!store_strobe_n_o [*1];
	endsequence

	sequence s_read_rise;
		!fetch_strobe_n_o ##1 fetch_strobe_n_o;
	endsequence

	store_drives_a: assert property (s_write_low |-> data_oe_o && address_oe_o)
		else $error("Data pins not driven while store strobe low.");
	write_only_a: assert property (!store_strobe_n_o |-> req_q.write && !done_o)
		else $error("Store strobe low outside a write.");
	data_hold_a: assert property ($rose(store_strobe_n_o) |-> data_oe_o && $stable(data_pins_o))
		else $error("Write data not held across store strobe rise.");
	qualify_hold_a: assert property ((!store_strobe_n_o || !fetch_strobe_n_o)
		|-> address_oe_o && strobe_oe_o && $stable(address_pins_o))
		else $error("Address changed while a strobe is low.");
	idle_float_a: assert property (state_q == ST_IDLE && !$past(bus_drive_hold_i)
		&& !$past(busy_d) |-> !address_oe_o && !strobe_oe_o)
		else $error("Bus driven while idle with hold off.");
	idle_drive_a: assert property ($past(bus_drive_hold_i) |-> address_oe_o && strobe_oe_o)
		else $error("Bus floated with hold on.");
	prog_cs_a: assert property (state_q == ST_STROBE && !req_q.data_space && hit_q == '0
		&& !$past(cs_gpio_mode_i[CS_PROG]) |-> !cs_n_o[CS_PROG])
		else $error("Program select not low on program access.");
	data_cs_a: assert property (state_q == ST_STROBE && req_q.data_space && hit_q == '0
		&& !$past(cs_gpio_mode_i[CS_DATA]) |-> !cs_n_o[CS_DATA])
		else $error("Data select not low on data access.");
	region_cs_a: assert property (state_q == ST_STROBE && hit_q[0]
		&& !$past(cs_gpio_mode_i[CS_REG0]) |-> !cs_n_o[CS_REG0])
		else $error("Region select not low on region access.");
	strobe_pu_a: assert property ($past(pullup_disable_ctrl_i) |-> !strobe_pu_o)
		else $error("Strobe pull-up on while disabled.");
	prog_pu_a: assert property (cs_pu_o[CS_PROG] == $past(port_d_pullup_i[PU_PROG_BIT]))
		else $error("Program select pull-up wrong.");
	data_pu_a: assert property (cs_pu_o[CS_DATA] == $past(port_d_pullup_i[PU_DATA_BIT]))
		else $error("Data select pull-up wrong.");
	gpio_dir_a: assert property ($past(cs_gpio_mode_i[CS_REG1])
		|-> cs_oe_o[CS_REG1] == $past(cs_gpio_dir_i[CS_REG1]))
		else $error("General-purpose pin direction not followed.");
	read_cap_a: assert property (s_read_rise |-> rdata_o == $past(data_pins_i) ##1 done_o)
		else $error("Read data not captured at fetch strobe rise.");
	one_cs_a: assert property ($onehot0(~(cs_n_o | $past(cs_gpio_mode_i))))
		else $error("More than one chip select low.");
	idle_cs_a: assert property (state_q == ST_IDLE && !$past(busy_d)
		|-> (cs_n_o | $past(cs_gpio_mode_i)) == '1)
		else $error("Chip select low between accesses.");

	// The checks guarded by !$past(rst_i) skip the first edge after reset, where the
	// registers still show their reset values rather than the previous inputs.
	localparam int DONE_LAT = int'(STROBE_CYCLES) + 3;

	sequence s_take;
		req_valid_i && req_ready_o;
	endsequence

	sequence s_strobe_fall;
		$fell(store_strobe_n_o) || $fell(fetch_strobe_n_o);
	endsequence

	access_len_a: assert property (s_take |-> ##DONE_LAT done_o)
		else $error("Access did not end after the fixed number of cycles.");
	done_pulse_a: assert property (done_o |=> !done_o)
		else $error("Done held longer than one cycle.");
	ready_idle_a: assert property (req_ready_o |-> state_q == ST_IDLE)
		else $error("Ready raised while an access runs.");
	setup_gap_a: assert property (s_strobe_fall |-> $past(state_q) == ST_SETUP)
		else $error("Strobe fell without a setup cycle.");
	strobe_excl_a: assert property (store_strobe_n_o || fetch_strobe_n_o)
		else $error("Store and fetch strobes low together.");
	fetch_read_a: assert property (!fetch_strobe_n_o |-> !req_q.write && !data_oe_o)
		else $error("Data pins driven during fetch strobe.");
	write_data_a: assert property ($fell(store_strobe_n_o) |-> data_pins_o == req_q.wdata)
		else $error("Write data not on the pins when store strobe fell.");
	addr_live_a: assert property (!store_strobe_n_o |-> address_pins_o == req_q.addr)
		else $error("Address pins do not carry the write address.");
	data_release_a: assert property ($rose(store_strobe_n_o) |=> !data_oe_o)
		else $error("Data pins still driven after the hold cycle.");
	data_idle_a: assert property (state_q == ST_IDLE |-> !data_oe_o)
		else $error("Data pins driven while idle.");
	strobe_cs_a: assert property ((!store_strobe_n_o || !fetch_strobe_n_o)
		&& $past(cs_gpio_mode_i) == '0 |-> !(&cs_n_o))
		else $error("No chip select low while a strobe is low.");
	region_one_a: assert property (state_q == ST_STROBE && hit_q == 2'b10
		&& !$past(cs_gpio_mode_i[CS_REG1]) |-> !cs_n_o[CS_REG1])
		else $error("Second region select not low on region access.");
	gpio_level_a: assert property ($past(cs_gpio_mode_i[CS_REG0])
		|-> cs_n_o[CS_REG0] == $past(cs_gpio_out_i[CS_REG0]))
		else $error("General-purpose pin level not followed.");
	gpio_in_a: assert property (!$past(rst_i) |-> cs_gpio_in_o == $past(cs_pin_i))
		else $error("General-purpose pin input not captured.");
	cs_oe_hold_a: assert property (!$past(rst_i) && $past(bus_drive_hold_i)
		&& !$past(cs_gpio_mode_i[CS_PROG]) |-> cs_oe_o[CS_PROG])
		else $error("Program select floated with hold on.");
	cs_oe_idle_a: assert property (!$past(rst_i) && !$past(bus_drive_hold_i)
		&& !$past(busy_d) && !$past(cs_gpio_mode_i[CS_DATA]) |-> !cs_oe_o[CS_DATA])
		else $error("Data select driven while idle with hold off.");
	strobe_pu_on_a: assert property (!$past(pullup_disable_ctrl_i) |-> strobe_pu_o)
		else $error("Strobe pull-up off while enabled.");
	reg_pu_a: assert property (!$past(rst_i) |-> cs_pu_o[CS_REG1:CS_REG0]
		== {$past(port_d_pullup_i[PU_REG1_BIT]), $past(port_d_pullup_i[PU_REG0_BIT])})
		else $error("Region select pull-ups wrong.");
endmodule : emsc_top
`default_nettype wire

// >>> hw/emsc_pkg.sv
// Purpose: Shared constants and types for the external memory strobe and select block.
// Assumes: 125 MHz system clock, synchronous pin inputs.
// Notes:   Timing counts are derived here from times in nanoseconds.
`default_nettype none
package emsc_pkg;
	localparam int unsigned ADDR_W       = 17;
	localparam int unsigned DATA_W       = 16;
	localparam int unsigned NUM_CS       = 4;
	localparam int unsigned NUM_REGION   = 2;
	localparam int unsigned CLK_PERIOD_NS = 8;
	// Least strobe low time; rounds up to whole cycles.
	localparam int unsigned STROBE_NS    = 16;
	localparam int unsigned STROBE_CYC   = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Chip select indices.
	localparam int unsigned CS_PROG      = 0;
	localparam int unsigned CS_DATA      = 1;
	localparam int unsigned CS_REG0      = 2;
	localparam int unsigned CS_REG1      = 3;
	// Port D pull-up bit positions of the shared select pins.
	localparam int unsigned PU_PROG_BIT  = 8;
	localparam int unsigned PU_DATA_BIT  = 9;
	localparam int unsigned PU_REG0_BIT  = 0;
	localparam int unsigned PU_REG1_BIT  = 1;
	// Reset values of pin registers.
	localparam logic        STROBE_RST   = 1'b1;
	localparam logic [3:0]  CS_N_RST     = 4'hF;
	localparam logic [3:0]  CS_PU_RST    = 4'hF;

	typedef struct packed {
		logic              write;
		logic              data_space;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} emsc_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] mask;
	} emsc_region_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_SETUP  = 4'h2,
		ST_STROBE = 4'h4,
		ST_HOLD   = 4'h8
	} emsc_state_t;
endpackage : emsc_pkg
`default_nettype wire

// >>> hw/emsc_region_dec.sv
// Purpose: Address match for the two programmable chip select regions.
// Assumes: Region settings are stable during an access.
// Notes:   Purely combinational; the caller registers the result.
`default_nettype none
module emsc_region_dec
	import emsc_pkg::*;
(
	input  wire logic [emsc_pkg::ADDR_W-1:0]                      addr_i,
	input  wire emsc_pkg::emsc_region_t [emsc_pkg::NUM_REGION-1:0] region_i,
	input  wire logic [emsc_pkg::NUM_REGION-1:0]                  region_en_i,
	output logic [emsc_pkg::NUM_REGION-1:0]                       hit_o
);
	for (genvar g = 0; g < NUM_REGION; g++) begin : g_region
		// Only address bits set in the mask take part in the compare.
		assign hit_o[g] = region_en_i[g] &&
			((addr_i & region_i[g].mask) == (region_i[g].base & region_i[g].mask));
	end
endmodule : emsc_region_dec
`default_nettype wire

// >>> hw/emsc_pin_cfg.sv
// Purpose: Pull-up enables and general-purpose input capture of the shared pins.
// Assumes: Control inputs are synchronous to clk_i.
// Notes:   All outputs are registered.
`default_nettype none
module emsc_pin_cfg
	import emsc_pkg::*;
(
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        pullup_disable_ctrl_i,
	input  wire logic [15:0]                 port_d_pullup_i,
	input  wire logic [emsc_pkg::NUM_CS-1:0] cs_pin_i,
	output logic                             strobe_pu_o,
	output logic [emsc_pkg::NUM_CS-1:0]      cs_pu_o,
	output logic [emsc_pkg::NUM_CS-1:0]      cs_gpio_in_o
);
	logic [NUM_CS-1:0] cs_pu_d;

	assign cs_pu_d[CS_PROG] = port_d_pullup_i[PU_PROG_BIT];
	assign cs_pu_d[CS_DATA] = port_d_pullup_i[PU_DATA_BIT];
	assign cs_pu_d[CS_REG0] = port_d_pullup_i[PU_REG0_BIT];
	assign cs_pu_d[CS_REG1] = port_d_pullup_i[PU_REG1_BIT];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			strobe_pu_o  <= 1'b1;
			cs_pu_o      <= CS_PU_RST;
			cs_gpio_in_o <= '0;
		end else begin
			strobe_pu_o  <= ~pullup_disable_ctrl_i;
			cs_pu_o      <= cs_pu_d;
			cs_gpio_in_o <= cs_pin_i;
		end
	end
endmodule : emsc_pin_cfg
`default_nettype wire

// >>> test/emsc_sram_model.sv
// Purpose: Static memory on the far side of the store and fetch strobes.
// Assumes: Only the low eight address bits are decoded; pins resolved by the bench.
// Notes:   A released data bus shows the inverse of its last value, never a hold.
`default_nettype none
module emsc_sram_model
	import emsc_pkg::*;
(
	input  wire logic                        clk_i,
	input  wire logic [emsc_pkg::ADDR_W-1:0] addr_i,
	input  wire logic                        sel_n_i,
	input  wire logic                        store_n_i,
	input  wire logic                        fetch_n_i,
	input  wire logic [emsc_pkg::DATA_W-1:0] wdata_i,
	output logic      [emsc_pkg::DATA_W-1:0] rdata_o
);
	logic [DATA_W-1:0] mem [256];
	logic [DATA_W-1:0] last_q = 16'h0000;
	logic              rd_on;

	////////////////////////////////////////////////////////////////////////
	assign rd_on   = !fetch_n_i && !sel_n_i;
	assign rdata_o = rd_on ? mem[addr_i[7:0]] : ~last_q;

	always @(posedge clk_i) begin
		last_q <= rdata_o;
	end

	// Capture on the strobe rise, so data that drops early is caught.
	always @(posedge store_n_i) begin
		if (!sel_n_i) begin
			mem[addr_i[7:0]] = wdata_i;
		end
	end
endmodule : emsc_sram_model
`default_nettype wire

// >>> test/tb_ext_mem_strobes_selects.sv
// Purpose: Self-checking bench for the strobe and select block.
// Assumes: Default strobe length; region hit when masked address equals masked base.
// Notes:   Undriven strobe and select pins read high at the memory; an undriven select shows cs_ext at cs_pin.
`default_nettype none
module tb_ext_mem_strobes_selects import emsc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned SC = 2;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_valid, ready, done, drive_hold, pud_ctrl;
	emsc_req_t req;
	emsc_region_t [NUM_REGION-1:0] region;
	logic [NUM_REGION-1:0] region_en;
	logic [DATA_W-1:0] rdata, dpo, dpi, mem_q;
	logic [NUM_CS-1:0] gmode, gout, gdir, cs_pin, gin, cs_ext, cs_n, cs_oe, cs_pu;
	logic [15:0] pd_pu;
	logic [ADDR_W-1:0] addr;
	logic addr_oe, store_n, fetch_n, strobe_oe, data_oe, strobe_pu;
	int n_mismatch = 0;
	int checks_done = 0;

	always #4 clk_i = ~clk_i;
	assign cs_pin = (cs_oe & cs_n) | (~cs_oe & cs_ext);
	assign dpi = data_oe ? dpo : mem_q;

	emsc_top #(.STROBE_CYCLES(SC)) dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid),
		.req_i(req), .req_ready_o(ready), .done_o(done), .rdata_o(rdata),
		.bus_drive_hold_i(drive_hold), .region_i(region), .region_en_i(region_en),
		.cs_gpio_mode_i(gmode), .cs_gpio_out_i(gout), .cs_gpio_dir_i(gdir), .cs_pin_i(cs_pin),
		.cs_gpio_in_o(gin), .pullup_disable_ctrl_i(pud_ctrl), .port_d_pullup_i(pd_pu),
		.address_pins_o(addr), .address_oe_o(addr_oe), .store_strobe_n_o(store_n),
		.fetch_strobe_n_o(fetch_n), .strobe_oe_o(strobe_oe), .data_pins_o(dpo),
		.data_oe_o(data_oe), .data_pins_i(dpi), .cs_n_o(cs_n), .cs_oe_o(cs_oe),
		.strobe_pu_o(strobe_pu), .cs_pu_o(cs_pu));

	emsc_sram_model mem_u (.clk_i(clk_i), .addr_i(addr), .sel_n_i(&(~cs_oe | cs_n)),
		.store_n_i(!strobe_oe || store_n), .fetch_n_i(!strobe_oe || fetch_n),
		.wdata_i(dpi), .rdata_o(mem_q));

	////////////////////////////////////////////////////////////////////////
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : check_val

	task automatic finish_test();
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask : tick

	// One access; watches every cycle of it and the idle state after done.
	task automatic access(input logic wr, input logic dsp, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] wd, input logic [NUM_CS-1:0] cs_exp);
		int cyc;
		int n_st;
		int n_fe;
		cyc = 0;
		n_st = 0;
		n_fe = 0;
		while (ready !== 1'b1 && cyc < 20) begin
			tick();
			cyc++;
		end
		req = '{write: wr, data_space: dsp, addr: a, wdata: wd};
		req_valid = 1'b1;
		tick();
		req_valid = 1'b0;
		cyc = 1;
		while (done !== 1'b1 && cyc < 20) begin
			if (store_n !== 1'b1 || fetch_n !== 1'b1) begin
				check_val(cs_n, cs_exp, "select");
				check_val(addr, a, "address");
			end
			if (store_n === 1'b0) begin
				n_st++;
				check_val({data_oe, dpo}, {1'b1, wd}, "write data");
			end
			if (fetch_n === 1'b0) begin
				n_fe++;
				check_val(data_oe, 1'b0, "data pins on read");
			end
			tick();
			cyc++;
		end
		check_val(cyc, 3 + SC, "access length");
		check_val(n_st, wr ? SC : 0, "store strobe cycles");
		check_val(n_fe, wr ? 0 : SC, "fetch strobe cycles");
		check_val({cs_n, store_n, fetch_n}, 6'h3F, "negated after");
		check_val({addr_oe, strobe_oe, cs_oe}, {6{drive_hold}}, "idle drive");
		if (!wr) begin
			check_val(rdata, wd, "read data");
		end
	endtask : access

	task automatic test_reset();
		check_val({ready, done, addr_oe, strobe_oe, data_oe, cs_oe}, 0, "reset drive");
		check_val({store_n, fetch_n, cs_n}, 6'h3F, "reset levels");
		check_val({strobe_pu, cs_pu}, 5'h1F, "reset pull-ups");
		$display("test reset done");
	endtask : test_reset

	task automatic test_spaces();
		drive_hold = 1'b1;
		access(1'b1, 1'b1, 17'h00005, 16'hA5C3, 4'b1101);
		access(1'b0, 1'b1, 17'h00005, 16'hA5C3, 4'b1101);
		access(1'b1, 1'b0, 17'h1FFFF, 16'h5AF0, 4'b1110);
		access(1'b0, 1'b0, 17'h1FFFF, 16'h5AF0, 4'b1110);
		drive_hold = 1'b0;
		access(1'b1, 1'b1, 17'h00007, 16'h0F0F, 4'b1101);
		drive_hold = 1'b1;
		$display("test spaces done");
	endtask : test_spaces

	task automatic test_regions();
		region[0] = '{base: 17'h10000, mask: 17'h1F000};
		region[1] = '{base: 17'h00000, mask: 17'h00000};
		region_en = 2'b11;
		access(1'b1, 1'b1, 17'h10010, 16'h1234, 4'b1011);
		access(1'b0, 1'b0, 17'h10010, 16'h1234, 4'b1011);
		region_en = 2'b10;
		access(1'b1, 1'b0, 17'h00020, 16'hBEEF, 4'b0111);
		region_en = 2'b00;
		access(1'b0, 1'b1, 17'h00020, 16'hBEEF, 4'b1101);
		$display("test regions done");
	endtask : test_regions

	task automatic test_pins();
		pud_ctrl = 1'b1;
		pd_pu = 16'h0201;
		gmode = 4'hC;
		gdir = 4'h4;
		gout = 4'h0;
		cs_ext = 4'h8;
		repeat (3) tick();
		check_val({strobe_pu, cs_pu}, 5'b00110, "pull-ups");
		check_val({cs_oe[3:2], cs_n[2], gin[3:2]}, 5'b01010, "general pins");
		gdir = 4'h8;
		pud_ctrl = 1'b0;
		pd_pu = 16'h0100;
		cs_ext = 4'h0;
		repeat (3) tick();
		check_val({strobe_pu, cs_pu}, 5'b10001, "pull-ups");
		check_val({cs_oe[3:2], cs_n[3], gin[3:2]}, 5'b10000, "general pins");
		gmode = 4'h0;
		$display("test pins done");
	endtask : test_pins

	////////////////////////////////////////////////////////////////////////
	initial begin
		req_valid = 1'b0;
		req = '0;
		drive_hold = 1'b0;
		region = '0;
		region_en = 2'b00;
		gmode = 4'h0;
		gout = 4'hF;
		gdir = 4'h0;
		cs_ext = 4'hF;
		pud_ctrl = 1'b0;
		pd_pu = 16'hFFFF;
		repeat (4) tick();
		test_reset();
		repeat (4) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		test_spaces();
		test_regions();
		test_pins();
		finish_test();
	end

	// The tests need well under 1000 cycles; this allows ten times that.
	initial begin
		#80000;
		n_mismatch++;
		$display("Error at %0t: watchdog expired", $time);
		finish_test();
	end
endmodule : tb_ext_mem_strobes_selects
`default_nettype wire
